// ### src/odl_link_ctrl.sv
`timescale 1ns/1ps
`include "odl_cfg.svh"
//Contract
//RQ1 - BREAK returns all link state to defaults, also leaving error or lost sync; the code keeps the measured baud until the next SYNCH
//RQ2 - Debugger sends two BREAKs back to back
//RQ3 - BREAK during receive gives frame error, during transmit contention error; aborts
//RQ4 - BREAK resets port clock divider selection to 4 MHz code
//RQ5 - SYNCH length held in 16-bit sample counter, at most 65535 cycles
//RQ6 - Unknown clock: debugger BREAK lasts 24.60 ms
//RQ7 - Known clock: debugger may shorten BREAK per clock selection
//RQ8 - SYNCH is eight-bit frame of value 0x55
//RQ9 - After disable, a SYNCH re-enables the port
//RQ10 - Counted SYNCH cycles set receive sampling and transmit bit time
//RQ11 - Debugger precedes each instruction with SYNCH, except inside REPEAT
//RQ12 - One-wire enable only with pin function bit set, else HV only
//RQ13 - Programmer pulls line low over 200 ns then releases
//RQ14 - Edge detector holds line low until port clock is ready
//RQ15 - Programmer polls line high then sends 0x55
//RQ16 - Enabling SYNCH baud serves the first instruction
//RQ17 - No SYNCH start bit in start window disables the port
//RQ18 - Programming key clears locks and sets programming-started flag
//RQ19 - Interface disable bit write resets port and drops clock request
//RQ20 - HV pulse forces pin, resets device, halts CPU until key or timeout
//RQ21 - Programmer applies HV after power-on reset and sends key in time
//RQ22 - HV override cleared only by power-on reset; the code also clears it at the HV key timeout
//RQ23 - Clock divider defaults to code 0x3 after reset and enable
//RQ24 - Start-up timeout after 65536 port cycles without SYNCH
//RQ25 - BREAK is line low longer than one whole frame
module odl_link_ctrl #(
  parameter int STARTUP_CYCLES = `ODL_STARTUP_CYCLES,
  parameter int HV_KEY_TIMEOUT = 100000
) (
  input  wire logic                       clock,
  input  wire logic                       nrst,
  input  wire logic                       por_event,
  input  wire logic                       line_in,
  output logic                            line_out,
  output logic                            line_oe,
  input  wire logic                       pin_function_select,
  input  wire logic                       hv_pulse,
  input  wire logic                       osc_ready,
  output logic                            clk_req,
  input  wire logic                       tx_active,
  input  wire logic                       clksel_wr,
  input  wire logic [1:0]                 clksel_wdata,
  output logic      [1:0]                 port_clock_divider_select,
  input  wire logic                       interface_disable_bit,
  input  wire logic                       nvm_programming_key,
  output logic                            programming_started_flag,
  output logic                            lock_bits_clear,
  output logic                            debug_pin_enabled,
  output logic                            cpu_halt,
  output logic                            system_reset_req,
  output logic      [15:0]                baud_count,
  output logic                            port_enabled,
  output logic                            link_error,
  output odl_pkg::odl_events_t            events,
  output logic      [`ODL_FIFO_WIDTH-1:0] rx_data,
  output logic                            rx_valid,
  input  wire logic                       rx_ready
);
  odl_pkg::odl_regs_t r_q;
  odl_pkg::odl_regs_t r_d;
  logic               fifo_in_ready;
  logic               rx_push;
  logic [7:0]         rx_byte;
  logic [15:0]        bit_time;
  logic [15:0]        break_len;
  logic               fell;
  logic               pin_usable;
  logic               brk;

  assign bit_time   = {3'h0, r_q.baud[15:3]};
  assign break_len  = 16'((32'(bit_time) * `ODL_FRAME_BITS) > 32'hFFFF ? 32'hFFFF :
                          32'(bit_time) * `ODL_FRAME_BITS);
  assign fell       = r_q.line_prev && !line_in;
  assign pin_usable = pin_function_select || r_q.hv_override; // [RQ12]
  assign brk        = !line_in && (r_q.low_cnt >= break_len) && (r_q.baud != 16'h0000); // [RQ25]

  always_comb begin
    r_d           = r_q;
    rx_push       = 1'b0;
    rx_byte       = r_q.shreg;
    r_d.line_prev = line_in;
    r_d.ev        = '0;
    r_d.sys_reset = 1'b0;
    r_d.low_cnt   = line_in ? 16'h0000 : (r_q.low_cnt == 16'hFFFF ? r_q.low_cnt : r_q.low_cnt + 16'h0001);
    if (clksel_wr && r_q.st != odl_pkg::ODL_OFF) begin
      r_d.clksel = clksel_wdata;
    end
    unique case (r_q.st)
      odl_pkg::ODL_OFF: begin
        r_d.clk_req = 1'b0;
        if (pin_usable && !line_in) begin
          r_d.cnt = r_q.cnt + 16'h0001;
          if (r_q.cnt >= 16'(`ODL_EDGE_MIN_CYC - 1)) begin
            r_d.st        = odl_pkg::ODL_WAKE;
            r_d.drive_low = 1'b1; // [RQ14]
            r_d.clk_req   = 1'b1;
            r_d.clksel    = `ODL_CLKSEL_RESET; // [RQ23]
          end
        end else begin
          r_d.cnt = 16'h0000;
        end
      end
      odl_pkg::ODL_WAKE: begin
        if (osc_ready) begin
          r_d.drive_low = 1'b0; // [RQ14]
          r_d.st        = odl_pkg::ODL_WAIT_SY;
          r_d.tmo       = 32'h0;
        end
      end
      odl_pkg::ODL_WAIT_SY: begin
        r_d.tmo = r_q.tmo + 32'h1;
        if (fell) begin
          r_d.st    = odl_pkg::ODL_MEASURE; // [RQ9]
          r_d.cnt   = 16'h0000;
          r_d.edges = 4'h0;
        end else if (r_q.tmo >= 32'(STARTUP_CYCLES - 1)) begin
          r_d.st      = odl_pkg::ODL_OFF; // [RQ17] [RQ24]
          r_d.clk_req = 1'b0;
          r_d.ev.startup_timeout = 1'b1;
        end
      end
      odl_pkg::ODL_MEASURE: begin
        // Start bit plus 0x55 gives five falling edges before the stop bit
        // Fifth fall closes eight bit times; edges all ones waits for the first fall
        if (r_q.edges == 4'hF) begin
          r_d.cnt = 16'h0000;
          if (fell) begin
            r_d.edges = 4'h0;
          end
        end else begin
          r_d.cnt = r_q.cnt + 16'h0001;
          if (r_q.cnt == `ODL_SAMPLE_MAX) begin
            r_d.st = odl_pkg::ODL_ERROR; // [RQ5]
            r_d.ev.synch_err = 1'b1;
          end else if (fell) begin
            r_d.edges = r_q.edges + 4'h1;
            if (r_q.edges == 4'h3) begin
              if (r_q.cnt < `ODL_SYNCH_MIN) begin
                r_d.st = odl_pkg::ODL_ERROR;
                r_d.ev.synch_err = 1'b1;
              end else begin
                r_d.baud = r_q.cnt + 16'h0001; // [RQ10] [RQ16] [RQ8]
                r_d.st   = odl_pkg::ODL_IDLE;
              end
            end
          end
        end
      end
      odl_pkg::ODL_IDLE: begin
        if (fell) begin
          r_d.st   = odl_pkg::ODL_RX;
          r_d.cnt  = {1'b0, bit_time[15:1]};
          r_d.bitn = 4'h0;
        end
      end
      odl_pkg::ODL_RX: begin
        // Sample mid-bit using the measured bit time
        if (r_q.cnt == 16'h0000) begin
          r_d.cnt  = bit_time - 16'h0001;
          r_d.bitn = r_q.bitn + 4'h1;
          if (r_q.bitn >= 4'h1 && r_q.bitn <= 4'h8) begin
            r_d.shreg = {line_in, r_q.shreg[7:1]};
          end
          if (r_q.bitn == 4'h9) begin
            if (!line_in) begin
              r_d.st = odl_pkg::ODL_ERROR; // [RQ3]
              r_d.ev.frame_err = 1'b1;
            end else begin
              // Byte is dropped while the FIFO is full
              rx_push = fifo_in_ready;
              r_d.st  = odl_pkg::ODL_IDLE;
            end
          end
        end else begin
          r_d.cnt = r_q.cnt - 16'h0001;
        end
      end
      odl_pkg::ODL_ERROR: begin
        r_d.cnt = 16'h0000;
      end
      default: begin
        r_d.st = odl_pkg::ODL_OFF;
      end
    endcase
    if (tx_active && !line_in && r_q.st == odl_pkg::ODL_IDLE) begin
      r_d.st = odl_pkg::ODL_ERROR; // [RQ3]
      r_d.ev.contention_err = 1'b1;
    end
    // A BREAK during a SYNCH measurement restarts it as well
    if (brk && (r_q.st == odl_pkg::ODL_IDLE || r_q.st == odl_pkg::ODL_ERROR ||
                (r_q.st == odl_pkg::ODL_MEASURE && r_q.edges != 4'hF))) begin
      r_d.st     = odl_pkg::ODL_MEASURE; // [RQ1]
      r_d.cnt    = 16'h0000;
      r_d.edges  = 4'hF;
      r_d.clksel = `ODL_CLKSEL_RESET; // [RQ4]
      r_d.ev.break_seen = 1'b1;
    end
    if (nvm_programming_key && r_q.st != odl_pkg::ODL_OFF) begin
      r_d.prog_started = 1'b1; // [RQ18]
      r_d.locks_clear  = 1'b1;
      r_d.cpu_halt     = 1'b0;
      r_d.hv_arm       = 1'b0;
    end
    if (hv_pulse && !r_q.hv_override) begin
      r_d.hv_override = 1'b1; // [RQ20]
      r_d.hv_arm      = 1'b1;
      r_d.hv_tmo      = 32'h0;
      r_d.cpu_halt    = 1'b1;
      r_d.sys_reset   = 1'b1;
    end else if (r_q.hv_arm) begin
      r_d.hv_tmo = r_q.hv_tmo + 32'h1;
      if (r_q.hv_tmo >= 32'(HV_KEY_TIMEOUT - 1)) begin
        r_d.hv_arm      = 1'b0; // [RQ20]
        r_d.cpu_halt    = 1'b0;
        r_d.sys_reset   = 1'b1;
        r_d.hv_override = 1'b0;
        r_d.st          = odl_pkg::ODL_OFF;
        r_d.clk_req     = 1'b0;
      end
    end
    if (interface_disable_bit && r_q.st != odl_pkg::ODL_OFF) begin
      r_d.st           = odl_pkg::ODL_OFF; // [RQ19]
      r_d.clk_req      = 1'b0;
      r_d.drive_low    = 1'b0;
      r_d.sys_reset    = 1'b1;
      r_d.cpu_halt     = 1'b0;
      r_d.prog_started = 1'b0;
      r_d.locks_clear  = 1'b0;
      r_d.clksel       = `ODL_CLKSEL_RESET;
    end
    if (por_event) begin
      r_d.hv_override = 1'b0; // [RQ22]
      r_d.hv_arm      = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      r_q           <= '0;
      r_q.st        <= odl_pkg::ODL_OFF;
      r_q.clksel    <= `ODL_CLKSEL_RESET; // [RQ23]
      r_q.line_prev <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  odl_fifo #(
    .WIDTH(`ODL_FIFO_WIDTH),
    .DEPTH(`ODL_FIFO_DEPTH)
  ) u_fifo (
    .clock    (clock),
    .nrst     (nrst),
    .flush    (r_q.ev.break_seen),
    .in_data  (rx_byte),
    .in_valid (rx_push),
    .in_ready (fifo_in_ready),
    .out_data (rx_data),
    .out_valid(rx_valid),
    .out_ready(rx_ready)
  );

  assign line_out                  = 1'b0;
  assign line_oe                   = r_q.drive_low;
  assign clk_req                   = r_q.clk_req;
  assign port_clock_divider_select = r_q.clksel;
  assign programming_started_flag  = r_q.prog_started;
  assign lock_bits_clear           = r_q.locks_clear;
  assign debug_pin_enabled         = pin_usable;
  assign cpu_halt                  = r_q.cpu_halt;
  assign system_reset_req          = r_q.sys_reset;
  assign baud_count                = r_q.baud;
  assign port_enabled              = (r_q.st != odl_pkg::ODL_OFF);
  assign link_error                = (r_q.st == odl_pkg::ODL_ERROR);
  assign events                    = r_q.ev;

  a_break_clksel: assert property (@(posedge clock) disable iff (!nrst)
    r_q.ev.break_seen |-> r_q.clksel == `ODL_CLKSEL_RESET) else $error("break left clksel"); // [RQ4]
  a_break_state: assert property (@(posedge clock) disable iff (!nrst)
    r_q.ev.break_seen |-> r_q.st == odl_pkg::ODL_MEASURE) else $error("break not reset"); // [RQ1]
  a_timeout_off: assert property (@(posedge clock) disable iff (!nrst)
    r_q.ev.startup_timeout |-> !r_q.clk_req && r_q.st == odl_pkg::ODL_OFF) else $error("timeout not off"); // [RQ24]
  a_disable_drop: assert property (@(posedge clock) disable iff (!nrst)
    interface_disable_bit && port_enabled && !por_event |=> !clk_req && !port_enabled) else $error("disable ignored"); // [RQ19]
  a_pin_gate: assert property (@(posedge clock) disable iff (!nrst)
    r_q.st == odl_pkg::ODL_OFF && !pin_usable |=> r_q.st == odl_pkg::ODL_OFF || interface_disable_bit || hv_pulse)
    else $error("enable without pin function"); // [RQ12]
  a_wake_hold: assert property (@(posedge clock) disable iff (!nrst)
    r_q.st == odl_pkg::ODL_WAKE && !osc_ready |-> line_oe) else $error("released before clock ready"); // [RQ14]
  a_key_flag: assert property (@(posedge clock) disable iff (!nrst)
    nvm_programming_key && port_enabled && !interface_disable_bit |=> programming_started_flag && lock_bits_clear)
    else $error("key not taken"); // [RQ18]
  a_hv_sticky: assert property (@(posedge clock) disable iff (!nrst)
    r_q.hv_override && !por_event && !r_q.hv_arm |=> r_q.hv_override) else $error("override dropped"); // [RQ22]
  a_hv_halt: assert property (@(posedge clock) disable iff (!nrst)
    hv_pulse && !r_q.hv_override |=> cpu_halt && system_reset_req) else $error("hv no halt"); // [RQ20]
  a_frame_err: assert property (@(posedge clock) disable iff (!nrst)
    r_q.ev.frame_err |-> r_q.st == odl_pkg::ODL_ERROR) else $error("frame error not error"); // [RQ3]
endmodule : odl_link_ctrl

// ### src/odl_cfg.svh
`ifndef ODL_CFG_SVH
`define ODL_CFG_SVH
`define ODL_SYNCH_VALUE      8'h55
`define ODL_CLKSEL_32MHZ     2'h0
`define ODL_CLKSEL_16MHZ     2'h1
`define ODL_CLKSEL_8MHZ      2'h2
`define ODL_CLKSEL_4MHZ      2'h3
`define ODL_CLKSEL_RESET     2'h3
`define ODL_SAMPLE_MAX       16'hFFFF
`define ODL_SYNCH_MIN        16'h0010
`define ODL_STARTUP_CYCLES   32'd65536
`define ODL_CLOCK_MHZ        32'd100
`define ODL_EDGE_MIN_NS      32'd200
`define ODL_EDGE_MIN_CYC     ((`ODL_EDGE_MIN_NS * `ODL_CLOCK_MHZ + 32'd999) / 32'd1000)
`define ODL_FRAME_BITS       32'd12
`define ODL_FIFO_DEPTH       16
`define ODL_FIFO_WIDTH       8
`endif

// ### src/odl_pkg.sv
package odl_pkg;
  typedef enum logic [2:0] {
    ODL_OFF     = 3'b000,
    ODL_WAKE    = 3'b001,
    ODL_WAIT_SY = 3'b010,
    ODL_MEASURE = 3'b011,
    ODL_IDLE    = 3'b100,
    ODL_RX      = 3'b101,
    ODL_ERROR   = 3'b110
  } odl_state_t;

  typedef struct packed {
    logic       frame_err;
    logic       contention_err;
    logic       synch_err;
    logic       startup_timeout;
    logic       break_seen;
  } odl_events_t;

  typedef struct packed {
    odl_state_t  st;
    logic [1:0]  clksel;
    logic [15:0] cnt;
    logic [31:0] tmo;
    logic [15:0] baud;
    logic [15:0] low_cnt;
    logic [3:0]  edges;
    logic [3:0]  bitn;
    logic [7:0]  shreg;
    logic        line_prev;
    logic        drive_low;
    logic        clk_req;
    logic        hv_override;
    logic        hv_arm;
    logic [31:0] hv_tmo;
    logic        cpu_halt;
    logic        sys_reset;
    logic        prog_started;
    logic        locks_clear;
    odl_events_t ev;
  } odl_regs_t;
endpackage : odl_pkg

// ### src/odl_fifo.sv
`timescale 1ns/1ps
module odl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;
  logic [WIDTH-1:0] rdata_q;
  logic             rvalid_q;

  assign full     = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign empty    = (wr_q == rd_q);
  assign in_ready = !full;
  assign push     = in_valid && !full;
  assign pop      = !empty && (!rvalid_q || out_ready);
  assign out_data  = rdata_q;
  assign out_valid = rvalid_q;

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst || flush) begin
      wr_q     <= '0;
      rd_q     <= '0;
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q     <= rd_q + 1'b1;
        rdata_q  <= mem[rd_q[AW-1:0]];
        rvalid_q <= 1'b1;
      end else if (out_ready) begin
        rvalid_q <= 1'b0;
      end
    end
  end
endmodule : odl_fifo

// ### verification/odl_prog_model.sv
`timescale 1ns/1ps
module odl_prog_model (
  input  wire logic clock,
  input  wire logic line,
  output logic      drive_low
);
  initial drive_low = 1'b0;

  // Called just after a rising edge; holds a level for n cycles
  task automatic hold(input logic lvl, input int n);
    #1 drive_low = !lvl;
    repeat (n) @(posedge clock);
  endtask : hold

  task automatic wake();
    hold(1'b0, 25);
    #1 drive_low = 1'b0;
  endtask : wake

  task automatic send_byte(input logic [7:0] b, input int bc);
    hold(1'b0, bc);
    for (int i = 0; i < 8; i++) hold(b[i], bc);
    hold(1'b1, bc);
  endtask : send_byte

  // Length given directly in clock cycles, followed by 40 cycles high
  task automatic send_break(input int n);
    hold(1'b0, n);
    hold(1'b1, 40);
  endtask : send_break

  task automatic poll_high(output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 200 && ok !== 1'b1; i++) begin
      @(posedge clock);
      ok = line;
    end
  endtask : poll_high
endmodule : odl_prog_model

// ### verification/test_one_wire_debug_link_control.sv
`timescale 1ns/1ps
module test_one_wire_debug_link_control;
  localparam int BC = 20;
  logic        clock, nrst, por_event, pin_function_select;
  logic        hv_pulse, osc_ready, tx_active, clksel_wr;
  logic        interface_disable_bit, nvm_programming_key, rx_ready;
  logic [1:0]  clksel_wdata;
  logic        line_out, line_oe, clk_req, programming_started_flag, lock_bits_clear;
  logic        debug_pin_enabled, cpu_halt, system_reset_req, port_enabled, link_error, rx_valid;
  logic [1:0]  port_clock_divider_select;
  logic [15:0] baud_count;
  logic [7:0]  rx_data;
  logic [7:0]  rxq[$];
  odl_pkg::odl_events_t events;
  wire         prog_low;
  wire         line_w = !(prog_low || (line_oe && !line_out));
  int          err_count = 0, cmp_count = 0, sysrst_cnt = 0, n, r, s;
  int          ev_n[5];

  always #5 clock = ~clock;

  // Event pulses last one cycle, so they are counted here
  always @(posedge clock) begin
    for (int k = 0; k < 5; k++) if (events[k] === 1'b1) ev_n[k]++;
    if (system_reset_req === 1'b1) sysrst_cnt++;
    if (rx_valid === 1'b1 && rx_ready === 1'b1) rxq.push_back(rx_data);
  end

  odl_link_ctrl #(.STARTUP_CYCLES(256), .HV_KEY_TIMEOUT(200)) DUT (
    .clock(clock), .nrst(nrst), .por_event(por_event), .line_in(line_w), .line_out(line_out),
    .line_oe(line_oe), .pin_function_select(pin_function_select), .hv_pulse(hv_pulse),
    .osc_ready(osc_ready), .clk_req(clk_req), .tx_active(tx_active), .clksel_wr(clksel_wr),
    .clksel_wdata(clksel_wdata), .port_clock_divider_select(port_clock_divider_select),
    .interface_disable_bit(interface_disable_bit), .nvm_programming_key(nvm_programming_key),
    .programming_started_flag(programming_started_flag), .lock_bits_clear(lock_bits_clear),
    .debug_pin_enabled(debug_pin_enabled), .cpu_halt(cpu_halt), .system_reset_req(system_reset_req),
    .baud_count(baud_count), .port_enabled(port_enabled), .link_error(link_error), .events(events),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready));

  odl_prog_model prog (.clock(clock), .line(line_w), .drive_low(prog_low));

  task automatic cyc(input int c);
    repeat (c) @(posedge clock);
  endtask : cyc

  task automatic check(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic finish_test();
    $display("errors %0d, checks %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test

  task automatic bring_up(input int bc);
    logic ok;
    cyc(1);
    prog.wake();
    cyc(3);
    check(line_oe === 1'b1 && clk_req === 1'b1, "edge detector idle");
    cyc(30);
    check(line_w === 1'b0, "line released early");
    #1 osc_ready = 1'b1;
    prog.poll_high(ok);
    check(ok === 1'b1, "line never released");
    prog.send_byte(8'h55, bc);
    cyc(5);
    check(port_enabled === 1'b1 && baud_count >= 16'(8 * bc) && baud_count <= 16'(9 * bc + 3), "baud");
    check(port_clock_divider_select === 2'h3, "divider after enable");
  endtask : bring_up

  task automatic t_enable();
    check(port_clock_divider_select === 2'h3 && line_oe === 1'b0 && clk_req === 1'b0, "reset");
    bring_up(BC);
    prog.send_byte(8'hA5, BC);
    cyc(5);
    check(rxq.size() == 1 && rxq[0] === 8'hA5, "first byte");
    rxq.delete();
  endtask : t_enable

  task automatic t_fifo();
    #1 rx_ready = 1'b0;
    // Sixteen stored words plus the registered output; the eighteenth byte is dropped
    for (int i = 0; i < 18; i++) prog.send_byte(8'(16 + i), BC);
    cyc(5);
    check(rx_valid === 1'b1 && rxq.size() == 0, "stalled fifo");
    #1 rx_ready = 1'b1;
    cyc(24);
    check(rxq.size() == 17, "fifo depth");
    for (int i = 0; i < 17; i++) check(rxq[i] === 8'(16 + i), "fifo order");
    rxq.delete();
  endtask : t_fifo

  task automatic t_break();
    #1 clksel_wr = 1'b1;
    clksel_wdata = 2'h1;
    cyc(1);
    #1 clksel_wr = 1'b0;
    cyc(2);
    check(port_clock_divider_select === 2'h1, "divider write");
    s = ev_n[0];
    prog.send_break(400);
    check(ev_n[0] > s && port_clock_divider_select === 2'h3, "break");
    prog.send_byte(8'h55, 30);
    cyc(5);
    check(baud_count >= 16'd240 && baud_count <= 16'd273, "resync");
  endtask : t_break

  task automatic t_errors();
    n = ev_n[4];
    s = ev_n[0];
    prog.hold(1'b0, 30);
    prog.hold(1'b1, 30);
    prog.send_break(600);
    prog.send_break(600);
    check(ev_n[4] > n && ev_n[0] > s, "frame error");
    prog.send_byte(8'h55, 30);
    n = ev_n[3];
    #1 tx_active = 1'b1;
    prog.send_break(600);
    #1 tx_active = 1'b0;
    prog.send_break(600);
    check(ev_n[3] > n, "contention");
    n = ev_n[2];
    prog.send_byte(8'h55, 1);
    cyc(5);
    check(ev_n[2] > n && link_error === 1'b1, "short synch");
    prog.send_break(600);
    prog.send_byte(8'h55, 30);
    cyc(5);
    check(link_error === 1'b0 && port_enabled === 1'b1, "recovery");
  endtask : t_errors

  task automatic t_disable();
    r = sysrst_cnt;
    #1 interface_disable_bit = 1'b1;
    cyc(1);
    #1 interface_disable_bit = 1'b0;
    cyc(3);
    check(port_enabled === 1'b0 && clk_req === 1'b0 && sysrst_cnt == r + 1, "disable");
    #1 osc_ready = 1'b0;
  endtask : t_disable

  task automatic t_timeout();
    cyc(1);
    prog.wake();
    cyc(30);
    #1 osc_ready = 1'b1;
    for (n = 0; n < 300 && line_w !== 1'b1; n++) cyc(1);
    s = ev_n[1];
    for (n = 0; n < 400 && ev_n[1] == s; n++) cyc(1);
    check(n >= 250 && n <= 262 && port_enabled === 1'b0 && clk_req === 1'b0, "timeout");
    #1 osc_ready = 1'b0;
  endtask : t_timeout

  task automatic t_hv();
    #1 pin_function_select = 1'b0;
    cyc(1);
    prog.wake();
    cyc(30);
    check(line_oe === 1'b0 && debug_pin_enabled === 1'b0, "wake refused");
    r = sysrst_cnt;
    #1 hv_pulse = 1'b1;
    cyc(1);
    #1 hv_pulse = 1'b0;
    cyc(3);
    check(debug_pin_enabled === 1'b1 && cpu_halt === 1'b1 && sysrst_cnt > r, "hv override");
    bring_up(4);
    #1 nvm_programming_key = 1'b1;
    cyc(1);
    #1 nvm_programming_key = 1'b0;
    cyc(3);
    check(cpu_halt === 1'b0 && programming_started_flag === 1'b1 && lock_bits_clear === 1'b1, "key");
    check(debug_pin_enabled === 1'b1, "override lost after key");
    #1 por_event = 1'b1;
    cyc(1);
    #1 por_event = 1'b0;
    cyc(3);
    check(debug_pin_enabled === 1'b0, "override kept after power-on reset");
    r = sysrst_cnt;
    #1 hv_pulse = 1'b1;
    cyc(1);
    #1 hv_pulse = 1'b0;
    cyc(210);
    check(cpu_halt === 1'b0 && sysrst_cnt >= r + 2 && debug_pin_enabled === 1'b0, "key timeout");
  endtask : t_hv

  initial begin
    clock = 1'b0;
    nrst = 1'b0;
    por_event = 1'b0;
    pin_function_select = 1'b1;
    hv_pulse = 1'b0;
    osc_ready = 1'b0;
    tx_active = 1'b0;
    clksel_wr = 1'b0;
    clksel_wdata = 2'h0;
    interface_disable_bit = 1'b0;
    nvm_programming_key = 1'b0;
    rx_ready = 1'b1;
    cyc(10);
    #1 nrst = 1'b1;
    cyc(1);
    t_enable();
    t_fifo();
    t_break();
    t_errors();
    t_disable();
    t_timeout();
    t_hv();
    finish_test();
  end

  initial begin
    #1000000;
    err_count++;
    $display("CHECK FAILED at %0t: run timed out", $time);
    finish_test();
  end
endmodule : test_one_wire_debug_link_control
